// >>> sbd_pkg.sv
/*
 * Shared constants and types for the diagnostic buffer command handler.
 * Assumes a whole ten-byte command block at once and a byte-wide data path on one controller clock.
 */
package sbd_pkg;

    // Operation codes of the two buffer commands.
    localparam logic [7:0] SBD_OP_WRITE_BUF = 8'h3b;
    localparam logic [7:0] SBD_OP_READ_BUF  = 8'h3c;

    // Mode field values.
    localparam logic [1:0] SBD_MODE_COMBINED = 2'h0;
    localparam logic [1:0] SBD_MODE_RSV1     = 2'h1;
    localparam logic [1:0] SBD_MODE_DATA     = 2'h2;
    localparam logic [1:0] SBD_MODE_DESCR    = 2'h3;

    // Sense keys reported with the completion.
    localparam logic [3:0] SBD_SENSE_NONE    = 4'h0;
    localparam logic [3:0] SBD_SENSE_ILLEGAL = 4'h5;

    // Header size, reserved header byte and default buffer address width.
    localparam logic [2:0] SBD_HDR_BYTES    = 3'h4;
    localparam logic [7:0] SBD_HDR_RESERVED = 8'h00;
    localparam int         SBD_BUF_AW       = 18;

    // Values after reset.
    localparam logic [23:0] SBD_AVAIL_RST = 24'h000000;

    // Ten-byte command block, byte 0 in the top bits.
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  ctl1;
        logic [7:0]  buf_id;
        logic [23:0] offset;
        logic [23:0] length;
        logic [7:0]  ctl9;
    } sbd_cdb_s;

    // Completion status of a command.
    typedef struct packed {
        logic       check;
        logic [3:0] sense_key;
    } sbd_status_s;

    typedef enum logic [2:0] {
        SBD_IDLE,
        SBD_WR,
        SBD_RD_NEXT,
        SBD_RD_WAIT,
        SBD_RD_SEND,
        SBD_DONE
    } sbd_state_e;

endpackage : sbd_pkg

// >>> sbd_buf_ram.sv
/*
 * Controller buffer memory: one write port, one registered read port.
 * Assumes the caller keeps addresses inside the array.
 */
`timescale 1ns/1ns
module sbd_buf_ram #(
    parameter int AW = 18
) (
    input  wire logic          mclk,    // Controller clock.
    input  wire logic          sys_rst, // Asynchronous reset, active high.
    input  wire logic          we,      // Write strobe.
    input  wire logic [AW-1:0] waddr,   // Write address.
    input  wire logic [7:0]    wdata,   // Write data.
    input  wire logic [AW-1:0] raddr,   // Read address.
    output logic      [7:0]    rdata    // Read data, one cycle after address.
);

    logic [7:0] mem [0:(2**AW)-1];

    // Store written bytes; the array itself has no reset.
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read so the output comes from a flip-flop.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : sbd_buf_ram

// >>> sbd_buffer_diag.sv
/*
 * Target-side handler for the write buffer and read buffer diagnostic
 * commands: decodes and checks the command block, moves bytes between the
 * bus phase logic and the buffer memory, and reports completion status.
 * Assumes the command, receive and send streams come from phase logic on
 * the same clock, so none of them is synchronised here.
 */
`timescale 1ns/1ns
module sbd_buffer_diag #(
    parameter int BUF_AW = sbd_pkg::SBD_BUF_AW
) (
    input  wire logic                mclk,       // Controller clock.
    input  wire logic                sys_rst,    // Bus or power reset, async.
    input  wire logic                cdb_valid,  // Command block offered.
    input  wire sbd_pkg::sbd_cdb_s   cdb,        // Command block bytes.
    output logic                     cdb_ready,  // Command block taken.
    input  wire logic                rx_valid,   // Data-out byte offered.
    input  wire logic [7:0]          rx_byte,    // Data-out byte.
    output logic                     rx_ready,   // Data-out byte taken.
    output logic                     tx_valid,   // Data-in byte offered.
    output logic      [7:0]          tx_byte,    // Data-in byte.
    input  wire logic                tx_ready,   // Data-in byte taken.
    output logic                     cmd_done,   // Command finished pulse.
    output sbd_pkg::sbd_status_s     cmd_status, // Status of last command.
    output logic      [23:0]         avail_len   // Data bytes stored by last write.
);
    import sbd_pkg::*;

    localparam logic [24:0] CAP     = 25'(2**BUF_AW);
    localparam logic [24:0] HDR25   = {22'h0, SBD_HDR_BYTES};
    localparam logic [2:0]  HDR_END = SBD_HDR_BYTES;

    sbd_state_e        state_reg, state_next;
    logic [23:0]       remain_reg, remain_next;
    logic [BUF_AW-1:0] addr_reg, addr_next;
    logic [2:0]        hdr_idx_reg, hdr_idx_next;
    logic              use_hdr_reg, use_hdr_next;
    logic [1:0]        mode_reg, mode_next;
    logic [31:0]       hdr_word_reg, hdr_word_next;
    logic [7:0]        tx_byte_reg, tx_byte_next;
    logic [23:0]       avail_reg, avail_next;
    logic [23:0]       wr_cnt_reg, wr_cnt_next;
    logic              done_reg;
    sbd_status_s       status_reg, status_next;
    logic [7:0]        ram_rdata;

    // Command block field decode.
    wire         cdb_fire = cdb_valid && cdb_ready;
    wire [1:0]   mode     = cdb.ctl1[1:0];
    wire         is_wr    = cdb.opcode == SBD_OP_WRITE_BUF;
    wire         is_rd    = cdb.opcode == SBD_OP_READ_BUF;
    wire         id_nz    = cdb.buf_id != 8'h00;
    wire [24:0]  len25    = {1'b0, cdb.length};
    wire [24:0]  off25    = {1'b0, cdb.offset};

    // Validity checks; combined mode disregards the ID and offset bytes.
    wire mode_rsv  = (mode == SBD_MODE_RSV1)
                   || (is_wr && mode == SBD_MODE_DESCR);
    wire id_bad    = id_nz && mode == SBD_MODE_DATA;
    wire comb_long = len25 > (CAP + HDR25);
    wire data_long = (len25 + off25) > CAP;
    wire wr_long   = (mode == SBD_MODE_COMBINED) ? comb_long : data_long;
    wire cmd_bad   = !(is_wr || is_rd) || mode_rsv || id_bad || (is_wr && wr_long);

    // Read byte totals for each mode.
    wire [24:0] comb_avail = {1'b0, avail_reg} + HDR25;
    wire [23:0] rd_comb    = (cdb.length == 24'h0) ? 24'h0 :
                             (len25 < comb_avail) ? cdb.length
                                                  : comb_avail[23:0];
    wire [24:0] room       = (off25 > CAP) ? 25'h0 : (CAP - off25);
    wire [23:0] rd_data    = (len25 < room) ? cdb.length : room[23:0];
    wire [23:0] rd_descr   = (len25 < HDR25) ? cdb.length : {21'h0, SBD_HDR_BYTES};
    wire [23:0] rd_total   = (mode == SBD_MODE_COMBINED) ? rd_comb :
                             (mode == SBD_MODE_DATA) ? rd_data : rd_descr;

    // Header word that precedes the data, top byte sent first.
    wire [31:0] hdr_comb  = {SBD_HDR_RESERVED, avail_reg};
    wire [31:0] hdr_descr = id_nz ? 32'h0000_0000
                                  : {SBD_HDR_RESERVED, CAP[23:0]};
    wire [31:0] hdr_start = (mode == SBD_MODE_DESCR) ? hdr_descr : hdr_comb;

    // Per-command start values.
    wire         st_hdr  = mode != SBD_MODE_DATA;
    wire [BUF_AW-1:0] st_addr = (mode == SBD_MODE_DATA) ? cdb.offset[BUF_AW-1:0]
                                                        : {BUF_AW{1'b0}};

    // Stream handshakes and memory strobes.
    wire in_hdr  = use_hdr_reg && (hdr_idx_reg != HDR_END);
    wire rx_fire = rx_valid && rx_ready;
    wire tx_fire = tx_valid && tx_ready;
    wire ram_we  = rx_fire && !in_hdr;

    assign cdb_ready  = state_reg == SBD_IDLE;
    assign rx_ready   = (state_reg == SBD_WR) && (remain_reg != 24'h0);
    assign tx_valid   = state_reg == SBD_RD_SEND;
    assign tx_byte    = tx_byte_reg;
    assign cmd_done   = done_reg;
    assign cmd_status = status_reg;
    assign avail_len  = avail_reg;

    // Next-state logic for the command sequencer.
    always_comb begin
        state_next    = state_reg;
        remain_next   = remain_reg;
        addr_next     = addr_reg;
        hdr_idx_next  = hdr_idx_reg;
        use_hdr_next  = use_hdr_reg;
        mode_next     = mode_reg;
        hdr_word_next = hdr_word_reg;
        tx_byte_next  = tx_byte_reg;
        avail_next    = avail_reg;
        wr_cnt_next   = wr_cnt_reg;
        status_next   = status_reg;
        case (state_reg)
            SBD_IDLE: begin
                if (cdb_fire) begin
                    status_next.check     = cmd_bad;
                    status_next.sense_key = cmd_bad ? SBD_SENSE_ILLEGAL
                                                    : SBD_SENSE_NONE;
                    mode_next     = mode;
                    use_hdr_next  = st_hdr;
                    hdr_idx_next  = st_hdr ? 3'h0 : HDR_END;
                    addr_next     = st_addr;
                    hdr_word_next = hdr_start;
                    wr_cnt_next   = 24'h0;
                    remain_next   = is_wr ? cdb.length : rd_total;
                    if (cmd_bad) begin
                        state_next = SBD_DONE;
                    end else if (is_wr) begin
                        state_next = SBD_WR;
                    end else begin
                        state_next = SBD_RD_NEXT;
                    end
                end
            end
            SBD_WR: begin
                if (remain_reg == 24'h0) begin
                    avail_next = wr_cnt_reg;
                    state_next = SBD_DONE;
                end else if (rx_fire) begin
                    remain_next = remain_reg - 24'h1;
                    if (in_hdr) begin
                        hdr_idx_next = hdr_idx_reg + 3'h1;
                    end else begin
                        addr_next   = addr_reg + BUF_AW'(1);
                        wr_cnt_next = wr_cnt_reg + 24'h1;
                    end
                end
            end
            SBD_RD_NEXT: begin
                if (remain_reg == 24'h0) begin
                    state_next = SBD_DONE;
                end else if (in_hdr) begin
                    tx_byte_next  = hdr_word_reg[31:24];
                    hdr_word_next = {hdr_word_reg[23:0], 8'h00};
                    hdr_idx_next  = hdr_idx_reg + 3'h1;
                    state_next    = SBD_RD_SEND;
                end else begin
                    state_next = SBD_RD_WAIT;
                end
            end
            SBD_RD_WAIT: begin
                tx_byte_next = ram_rdata;
                addr_next    = addr_reg + BUF_AW'(1);
                state_next   = SBD_RD_SEND;
            end
            SBD_RD_SEND: begin
                if (tx_ready) begin
                    remain_next = remain_reg - 24'h1;
                    state_next  = SBD_RD_NEXT;
                end
            end
            SBD_DONE: begin
                state_next = SBD_IDLE;
            end
            default: begin
                state_next = SBD_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= SBD_IDLE;
            remain_reg   <= 24'h0;
            addr_reg     <= {BUF_AW{1'b0}};
            hdr_idx_reg  <= 3'h0;
            use_hdr_reg  <= 1'b0;
            mode_reg     <= SBD_MODE_COMBINED;
            hdr_word_reg <= 32'h0;
            tx_byte_reg  <= 8'h00;
            avail_reg    <= SBD_AVAIL_RST;
            wr_cnt_reg   <= 24'h0;
            status_reg   <= '0;
            done_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            remain_reg   <= remain_next;
            addr_reg     <= addr_next;
            hdr_idx_reg  <= hdr_idx_next;
            use_hdr_reg  <= use_hdr_next;
            mode_reg     <= mode_next;
            hdr_word_reg <= hdr_word_next;
            tx_byte_reg  <= tx_byte_next;
            avail_reg    <= avail_next;
            wr_cnt_reg   <= wr_cnt_next;
            status_reg   <= status_next;
            done_reg     <= state_reg == SBD_DONE;
        end
    end

    // Buffer memory; the read address is the current pointer.
    sbd_buf_ram #(
        .AW (BUF_AW)
    ) u_ram (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .we      (ram_we),
        .waddr   (addr_reg),
        .wdata   (rx_byte),
        .raddr   (addr_reg),
        .rdata   (ram_rdata)
    );

    // Count of bytes sent in the current command, saturating, for checking.
    logic [2:0] sent_cnt_reg;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sent_cnt_reg <= 3'h0;
        end else if (cdb_fire) begin
            sent_cnt_reg <= 3'h0;
        end else if (tx_fire && sent_cnt_reg != 3'h7) begin
            sent_cnt_reg <= sent_cnt_reg + 3'h1;
        end
    end

    // A rejected command moves no data and ends with an illegal request.
    sequence s_reject_end;
        !tx_valid && !rx_ready ##1 cmd_done && cmd_status.check
            && cmd_status.sense_key == SBD_SENSE_ILLEGAL;
    endsequence

    a_reserved_mode_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && mode == SBD_MODE_RSV1 |=> s_reject_end)
        else $error("reserved mode not rejected");

    a_write_id_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && is_wr && mode == SBD_MODE_DATA && id_nz |=> s_reject_end)
        else $error("nonzero write buffer id not rejected");

    a_write_too_long: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && is_wr && mode == SBD_MODE_COMBINED && comb_long |=> s_reject_end)
        else $error("oversized write not rejected");

    a_zero_alloc_empty: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && is_rd && mode == SBD_MODE_COMBINED && cdb.length == 24'h0
        |=> !tx_valid [*2] ##1 cmd_done && !cmd_status.check)
        else $error("zero allocation read sent bytes");

    a_header_first_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_valid && use_hdr_reg && hdr_idx_reg == 3'h1 |-> tx_byte == SBD_HDR_RESERVED)
        else $error("first header byte not zero");

    a_descr_four_max: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_valid && mode_reg == SBD_MODE_DESCR |-> sent_cnt_reg < 3'h4)
        else $error("descriptor read sent more than four bytes");

    a_header_not_stored: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_fire && use_hdr_reg && hdr_idx_reg < HDR_END |-> !ram_we ##1 $changed(hdr_idx_reg))
        else $error("header byte written to buffer");

    a_read_stop_done: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SBD_RD_NEXT && remain_reg == 24'h0 |=> !tx_valid ##1 cmd_done)
        else $error("read did not stop at its limit");

    a_avail_update: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SBD_WR && remain_reg == 24'h0 |=> avail_len == $past(wr_cnt_reg))
        else $error("available length not updated after write");

    a_tx_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("send byte dropped before taken");

    a_read_id_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && is_rd && mode == SBD_MODE_DATA && id_nz |=> s_reject_end)
        else $error("nonzero read buffer id not rejected");

    a_data_overrun_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && is_wr && mode == SBD_MODE_DATA && data_long |=> s_reject_end)
        else $error("data-mode write overrun not rejected");

    a_write_descr_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && is_wr && mode == SBD_MODE_DESCR |=> s_reject_end)
        else $error("reserved write mode three not rejected");

    a_bad_opcode_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && !is_wr && !is_rd |=> s_reject_end)
        else $error("unknown operation code not rejected");

    a_data_contiguous: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_fire && !in_hdr |-> ram_we ##1 addr_reg == $past(addr_reg) + BUF_AW'(1))
        else $error("stored byte not followed by next address");

    a_mem_byte_sent: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SBD_RD_WAIT |=> tx_valid && tx_byte == $past(ram_rdata))
        else $error("buffer byte not offered as read");

    a_header_msb_first: assert property (@(posedge mclk) disable iff (sys_rst)
        state_reg == SBD_RD_NEXT && remain_reg != 24'h0 && in_hdr
        |=> tx_valid && {tx_byte, 24'h0} == ($past(hdr_word_reg) & 32'hff00_0000))
        else $error("header byte not sent top byte first");

    a_comb_read_accept: assert property (@(posedge mclk) disable iff (sys_rst)
        cdb_fire && is_rd && mode == SBD_MODE_COMBINED |=> !cmd_status.check)
        else $error("combined read refused for ignored bytes");

endmodule : sbd_buffer_diag

// >>> sbd_init_model.sv
/*
 * Initiator model for the buffer command handler: offers command blocks,
 * feeds data-out bytes from a queue and collects data-in bytes.
 * Assumes it shares the handler's clock and drives on the falling edge.
 */
`timescale 1ns/1ns
module sbd_init_model (
    input  wire logic         mclk,      // Controller clock.
    output logic              cdb_valid, // Command block offered.
    output sbd_pkg::sbd_cdb_s cdb,       // Command block bytes.
    input  wire logic         cdb_ready, // Command block taken.
    output logic              rx_valid,  // Data-out byte offered.
    output logic [7:0]        rx_byte,   // Data-out byte.
    input  wire logic         rx_ready,  // Data-out byte taken.
    input  wire logic         tx_valid,  // Data-in byte offered.
    input  wire logic [7:0]   tx_byte,   // Data-in byte.
    output logic              tx_ready   // Data-in byte taken.
);
    import sbd_pkg::*;

    logic [7:0] rx_q[$];  // Bytes still to send.
    logic [7:0] got_q[$]; // Bytes received.
    logic       slow;     // Pace with gaps and stalls when set.
    logic       gap;      // Idle slot after a taken byte.
    logic       tick;     // Alternating sink stall.

    // Everything idle at time zero.
    initial begin
        cdb_valid = 1'b0;
        cdb       = '0;
        rx_valid  = 1'b0;
        rx_byte   = 8'h00;
        tx_ready  = 1'b0;
        slow      = 1'b0;
        gap       = 1'b0;
        tick      = 1'b0;
    end

    // Offers one block and holds it until the edge that takes it; then scrambles it.
    task automatic issue(input sbd_cdb_s c);
        cdb       = c;
        cdb_valid = 1'b1;
        while (cdb_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        cdb_valid = 1'b0;
        cdb       = ~c;
    endtask : issue

    // Feeds the stream without pause, or with a gap after each byte when slow.
    // Slow pacing stands for a host that only just keeps up.
    always @(negedge mclk) begin
        rx_valid <= (rx_q.size() > 0) && !gap;
        rx_byte  <= ((rx_q.size() > 0) && !gap) ? rx_q[0] : ~rx_byte;
        tx_ready <= !(slow && tick);
    end

    // Retires taken bytes and records bytes sent by the handler.
    always @(posedge mclk) begin
        gap  <= 1'b0;
        tick <= ~tick;
        if (rx_valid && rx_ready) begin
            void'(rx_q.pop_front());
            gap <= slow;
        end
        if (tx_valid && tx_ready) got_q.push_back(tx_byte);
    end
endmodule : sbd_init_model

// >>> testbench.sv
/*
 * Self-checking bench for the buffer command handler with a 16-byte buffer.
 * Assumes the package, the handler and the initiator model are compiled first.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module testbench;
    import sbd_pkg::*;

    localparam int          AW  = 4;
    localparam logic [23:0] CAP = 24'h000010; // Capacity with AW of 4.

    logic        mclk, sys_rst, cdb_valid, cdb_ready, rx_valid, rx_ready;
    logic        tx_valid, tx_ready, cmd_done;
    logic [7:0]  rx_byte, tx_byte;
    logic [23:0] avail_len;
    sbd_cdb_s    cdb;
    sbd_status_s cmd_status;
    int          bad_count, tests_run;
    logic [7:0]  din[$], exp_q[$];

    // Free-running controller clock.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    sbd_buffer_diag #(.BUF_AW(AW)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .cdb_valid(cdb_valid), .cdb(cdb), .cdb_ready(cdb_ready), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .cmd_done(cmd_done), .cmd_status(cmd_status),
        .avail_len(avail_len));
    sbd_init_model u_init (.mclk(mclk), .cdb_valid(cdb_valid), .cdb(cdb),
        .cdb_ready(cdb_ready), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

    // Builds a ten-byte block with the mode in the low bits of byte 1.
    function automatic sbd_cdb_s mk(logic [7:0] op, logic [1:0] md, logic [7:0] id,
                                    logic [23:0] off, logic [23:0] len);
        mk = '{opcode: op, ctl1: {6'h00, md}, buf_id: id, offset: off, length: len,
               ctl9: 8'h00};
    endfunction : mk

    // Runs one command with queued data, then judges status and data-in bytes.
    task automatic run(input sbd_cdb_s c, input logic ck);
        int n;
        u_init.got_q.delete();
        u_init.rx_q = din;
        u_init.issue(c);
        n = 0;
        while (cmd_done !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n < 500, 1'b1)
        `CHK(cmd_status, ck ? {1'b1, SBD_SENSE_ILLEGAL} : {1'b0, SBD_SENSE_NONE})
        `CHK(u_init.got_q.size(), exp_q.size())
        foreach (exp_q[i]) `CHK(u_init.got_q[i], exp_q[i])
        `CHK(u_init.rx_q.size(), 0)
        din.delete();
        exp_q.delete();
        @(negedge mclk);
    endtask : run

    // Idle outputs right after reset.
    task automatic t_reset();
        `CHK(cdb_ready, 1'b1)
        `CHK(tx_valid, 1'b0)
        `CHK(cmd_done, 1'b0)
        `CHK(avail_len, SBD_AVAIL_RST)
        $display("test reset done");
    endtask : t_reset

    // Combined write then combined reads clipped in every way, slow initiator.
    task automatic t_comb();
        u_init.slow = 1'b1;
        din = '{8'h00, 8'h00, 8'h00, 8'h09, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4};
        run(mk(SBD_OP_WRITE_BUF, SBD_MODE_COMBINED, 8'h07, 24'h3, 24'h9), 1'b0);
        `CHK(avail_len, 24'h000005)
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h05, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_COMBINED, 8'h03, 24'h2, 24'he),
            1'b0);
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h05, 8'hd0, 8'hd1};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_COMBINED, 8'h00, 24'h0, 24'h6),
            1'b0);
        exp_q = '{8'h00, 8'h00};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_COMBINED, 8'h00, 24'h0, 24'h2), 1'b0);
        run(mk(SBD_OP_READ_BUF, SBD_MODE_COMBINED, 8'h00, 24'h0, 24'h0), 1'b0);
        u_init.slow = 1'b0;
        $display("test combined done");
    endtask : t_comb

    // Fills the whole buffer, then one byte too many is refused.
    task automatic t_full();
        din = '{8'h00, 8'h00, 8'h00, 8'h14};
        for (int i = 0; i < 16; i++) din.push_back(8'h40 + 8'(i));
        run(mk(SBD_OP_WRITE_BUF, SBD_MODE_COMBINED, 8'h00, 24'h0, CAP + 24'h4), 1'b0);
        `CHK(avail_len, CAP)
        run(mk(SBD_OP_WRITE_BUF, SBD_MODE_COMBINED, 8'h00, 24'h0, CAP + 24'h5), 1'b1);
        $display("test full done");
    endtask : t_full

    // Data-mode write at an offset, reads around it, and an overrun.
    task automatic t_data();
        din = '{8'ha0, 8'ha1, 8'ha2};
        run(mk(SBD_OP_WRITE_BUF, SBD_MODE_DATA, 8'h00, 24'h2, 24'h3), 1'b0);
        `CHK(avail_len, 24'h000003)
        exp_q = '{8'h40, 8'h41, 8'ha0, 8'ha1, 8'ha2, 8'h45};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_DATA, 8'h00, 24'h0, 24'h6), 1'b0);
        exp_q = '{8'h4e, 8'h4f};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_DATA, 8'h00, 24'he, 24'h2), 1'b0);
        run(mk(SBD_OP_WRITE_BUF, SBD_MODE_DATA, 8'h00, 24'ha, 24'h7), 1'b1);
        $display("test data done");
    endtask : t_data

    // Descriptor reads: capacity, clipping and zeros for another buffer.
    task automatic t_descr();
        exp_q = '{8'h00, CAP[23:16], CAP[15:8], CAP[7:0]};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_DESCR, 8'h00, 24'h0, 24'h9), 1'b0);
        exp_q = '{8'h00, 8'h00};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_DESCR, 8'h00, 24'h0, 24'h2), 1'b0);
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
        run(mk(SBD_OP_READ_BUF, SBD_MODE_DESCR, 8'h05, 24'h0, 24'h4), 1'b0);
        $display("test descriptor done");
    endtask : t_descr

    // Every refused block ends with illegal request and moves no data.
    task automatic t_reject();
        sbd_cdb_s bad[6];
        bad = '{mk(SBD_OP_WRITE_BUF, SBD_MODE_DATA, 8'h01, 24'h0, 24'h2),
                mk(SBD_OP_READ_BUF, SBD_MODE_DATA, 8'h02, 24'h0, 24'h2),
                mk(SBD_OP_WRITE_BUF, SBD_MODE_RSV1, 8'h00, 24'h0, 24'h2),
                mk(SBD_OP_WRITE_BUF, SBD_MODE_DESCR, 8'h00, 24'h0, 24'h2),
                mk(SBD_OP_READ_BUF, SBD_MODE_RSV1, 8'h00, 24'h0, 24'h2),
                mk(8'h3d, SBD_MODE_COMBINED, 8'h00, 24'h0, 24'h2)};
        foreach (bad[i]) run(bad[i], 1'b1);
        $display("test reject done");
    endtask : t_reject

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end

    // Main sequence.
    initial begin
        sys_rst   = 1'b1;
        bad_count = 0;
        tests_run = 0;
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_comb();
        t_full();
        t_data();
        t_descr();
        t_reject();
        end_sim();
    end
endmodule : testbench
